//--- bench/acc_tb.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Comparator modelled from an integer input level
// Notes:   Bus reads poll the end-of-conversion flag; bus answers are taken at the rising edge
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    // ============================================================
    // Signals and model state
    logic        sys_clk_i        = 1'b0;
    logic        rst_i            = 1'b1;
    logic [8:0]  avs_address_i    = 9'h000;
    logic        avs_read_i       = 1'b0;
    logic        avs_write_i      = 1'b0;
    logic [31:0] avs_writedata_i  = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic        halt_i           = 1'b0;
    logic        ana_cmp_i        = 1'b0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        ana_power_o;
    logic [3:0]  ana_channel_o;
    logic        ana_sample_o;
    logic [9:0]  ana_trial_o;
    int          vin              = 0;
    int          miscompares      = 0;
    int          num_checks       = 0;
    localparam logic [8:0] CSR = 9'h1c0, RHI = 9'h1c4, RLO = 9'h1c8;

    acc_top #(.ADDR_W(9), .STAB_CYC(16'h0004)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .halt_i(halt_i),
        .ana_cmp_i(ana_cmp_i), .ana_power_o(ana_power_o), .ana_channel_o(ana_channel_o),
        .ana_sample_o(ana_sample_o), .ana_trial_o(ana_trial_o));

    always #20 sys_clk_i = ~sys_clk_i;
    // One cycle of lag is harmless: the trial code holds for at least two cycles
    always @(posedge sys_clk_i) ana_cmp_i <= (vin >= int'(ana_trial_o));

    // ============================================================
    // Tasks
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        n = 0;
        // Values read here are those the slave showed at this edge, before its own updates
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [8:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_flag();
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            rd(CSR, q);
            n++;
        end while (q[7] !== 1'b1 && n < 200);
        if (n >= 200) begin
            miscompares++;
            complete_run();
        end
    endtask

    task automatic check_result();
        logic [31:0] q;
        logic [9:0]  e;
        e = (vin < 0) ? 10'h000 : (vin > 1023) ? 10'h3ff : vin[9:0];
        rd(RLO, q);
        `CHK(q, {30'h0, e[1:0]})
        rd(RHI, q);
        `CHK(q, {24'h0, e[9:2]})
        rd(CSR, q);
        `CHK(q[7], 1'b0)
    endtask

    // Fresh conversion: power down, then up, then time one bit step
    task automatic conv(input int v, input logic spd, input logic [3:0] ch);
        int n;
        vin = v;
        wr(CSR, {2'b00, 2'b00, ch});
        wr(CSR, {1'b0, spd, 1'b1, 1'b0, ch});
        n = 0;
        while (ana_sample_o !== 1'b1 && n < 100) begin @(negedge sys_clk_i); n++; end
        if (n >= 100) begin
            miscompares++;
            complete_run();
        end
        `CHK(ana_power_o, 1'b1)
        `CHK(ana_channel_o, ch)
        while (!(ana_trial_o === 10'h200 && ana_sample_o === 1'b0) && n < 200) begin @(negedge sys_clk_i); n++; end
        if (n >= 200) begin
            miscompares++;
            complete_run();
        end
        n = 0;
        while (ana_trial_o === 10'h200 && n < 20) begin @(negedge sys_clk_i); n++; end
        `CHK(n, spd ? 2 : 4)
        @(posedge sys_clk_i);
        wait_flag();
        check_result();
        wait_flag();
        check_result();
    endtask

    // ============================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        int          vals [8];
        void'($urandom(53));
        vals = '{0, 1023, 2000, -5, 0, 0, 0, 0};
        for (int i = 4; i < 8; i++) vals[i] = $urandom % 1024;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        foreach (vals[i]) if (i < 4) begin
            rd(CSR + 9'(4 * i), q);
            `CHK(q, 32'h0)
        end
        avs_byteenable_i <= 4'h0;
        wr(CSR, 8'h65);
        avs_byteenable_i <= 4'hf;
        rd(CSR, q);
        `CHK(q, 32'h0)
        wr(CSR, 8'hd5);
        rd(CSR, q);
        `CHK(q, 32'h45)
        wr(RHI, 8'hff);
        wr(RLO, 8'hff);
        rd(RHI, q);
        `CHK(q, 32'h0)
        rd(RLO, q);
        `CHK(q, 32'h0)
        foreach (vals[i]) conv(vals[i], i[0], 4'($urandom));
        // Channel change in mid-conversion must restart on the new input
        conv(100, 1'b1, 4'h3);
        wait_flag();
        rd(RHI, q);
        repeat (4) @(posedge sys_clk_i);
        vin = 900;
        wr(CSR, 8'h65);
        rd(CSR, q);
        `CHK(q, 32'h65)
        `CHK(ana_channel_o, 4'h5)
        wait_flag();
        check_result();
        wait_flag();
        wr(CSR, 8'h65);
        rd(CSR, q);
        `CHK(q[7], 1'b0)
        wr(CSR, 8'h45);
        repeat (100) @(posedge sys_clk_i);
        rd(CSR, q);
        `CHK(q, 32'h45)
        `CHK(ana_power_o, 1'b0)
        wr(CSR, 8'h65);
        halt_i <= 1'b1;
        repeat (4) @(negedge sys_clk_i);
        `CHK(ana_power_o, 1'b0)
        @(posedge sys_clk_i);
        halt_i <= 1'b0;
        vin = 333;
        repeat (3) @(negedge sys_clk_i);
        `CHK(ana_sample_o, 1'b0)
        @(posedge sys_clk_i);
        // First result after wakeup is discarded; reading the high byte clears the flag
        wait_flag();
        rd(RHI, q);
        wait_flag();
        check_result();
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge sys_clk_i);
        miscompares++;
        complete_run();
    end
endmodule // testbench

//--- logic/acc_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: Constants come from acc_regs.svh
// Notes:   All state of a module is one packed struct
package acc_pkg;

    typedef struct packed {
        logic       speed;
        logic       on;
        logic [3:0] ch;
    } acc_ctrl_t;

    typedef enum logic [1:0] {
        SAR_IDLE   = 2'b00,
        SAR_SAMPLE = 2'b01,
        SAR_BITS   = 2'b10
    } acc_sar_state_t;

    typedef struct packed {
        acc_sar_state_t state;
        logic [3:0]     cnt;
        logic [9:0]     trial;
        logic [9:0]     result;
        logic           done;
        logic           sample;
    } acc_sar_st_t;

    typedef struct packed {
        acc_ctrl_t  ctrl;
        logic       eoc;
        logic [9:0] res;
        logic       waitreq;
        logic [7:0] rdata;
        logic [1:0] div;
        logic       tick;
        logic [15:0] stab;
        logic       power;
        logic [3:0] chan;
    } acc_top_st_t;

endpackage

//--- logic/acc_regs.svh
// Purpose: Register map, field positions, reset values and timing counts of the converter control block
// Assumes: 25 MHz system clock, registers reached over a 32-bit Avalon-MM slave
// Notes:   Byte address of a register is four times its index
//
// What this block does
// RULE1 - Reading the high result register clears the end-of-conversion flag.
// RULE2 - Writing a new channel select aborts the running conversion, clears the flag and restarts on the new input.
// RULE3 - Hardware sets the flag when a conversion ends; a high result read or any control write clears it.
// RULE4 - The flag bit is read-only; the other control bits are read/write.
// RULE5 - Rate select 0 runs the converter at the clock divided by four, 1 at the clock divided by two.
// RULE6 - Converter on set enables and starts conversion; cleared it stops any conversion and powers down.
// RULE7 - Channel select is a plain binary index of the analog input, 0 to 15.
// RULE8 - The CPU wait mode has no effect on the converter.
// RULE9 - Deep halt disables the converter; after wakeup results wait out a stabilization interval.
// RULE10 - The high result register is read-only and shows result bits 9:2 in bits 7:0.
// RULE11 - The low result register is read-only, shows result bits 1:0 and reads zero in bits 7:2.
// RULE12 - Reset clears the control register and both result registers.
// RULE13 - While enabled the converter repeats conversions on the selected channel back to back.
// RULE14 - Software reads both result registers before the next conversion ends, low one first.
// RULE15 - Inputs above the upper reference give all ones, below the lower give zero, with no overflow flag.
// RULE16 - A conversion lasts a fixed number of converter ticks and results update as the flag sets.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ============================================================
// Register indices
`define ACC_IDX_CSR      7'h70
`define ACC_IDX_RES_HI   7'h71
`define ACC_IDX_RES_LO   7'h72

// ============================================================
// Control/status fields
`define ACC_EOC_BIT      7
`define ACC_SPEED_BIT    6
`define ACC_ON_BIT       5
`define ACC_CH_MSB       3
`define ACC_CH_LSB       0
`define ACC_CSR_RST      8'h00
`define ACC_RES_RST      10'h000

// ============================================================
// Timing
`define ACC_DIV_FAST     2'h1
`define ACC_DIV_SLOW     2'h3
`define ACC_SAMPLE_TICKS 4'h2
`define ACC_RES_BITS     4'ha

`endif

//--- logic/acc_sar.sv
// Purpose: Successive approximation sequencer, one step per converter tick
// Assumes: cmp_i high when the sampled input is at or above the trial code
// Notes:   Abort wins over start
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_sar (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic       cmp_i,
    output logic            busy_o,
    output logic            done_o,
    output logic            sample_o,
    output logic [9:0]      trial_o,
    output logic [9:0]      result_o
);
    acc_pkg::acc_sar_st_t st_r;
    acc_pkg::acc_sar_st_t st_nxt;

    // ============================================================
    // Sequencer
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        case (st_r.state)
            acc_pkg::SAR_IDLE: begin
                if (start_i) begin
                    st_nxt.state  = acc_pkg::SAR_SAMPLE;
                    st_nxt.cnt    = 4'h0;
                    st_nxt.sample = 1'b1;
                end
            end
            acc_pkg::SAR_SAMPLE: begin
                if (tick_i) begin
                    st_nxt.cnt = st_r.cnt + 4'h1;
                    if (st_r.cnt == `ACC_SAMPLE_TICKS - 4'h1) begin
                        st_nxt.state  = acc_pkg::SAR_BITS;
                        st_nxt.sample = 1'b0;
                        st_nxt.cnt    = `ACC_RES_BITS - 4'h1;
                        st_nxt.trial  = 10'h200;
                    end
                end
            end
            acc_pkg::SAR_BITS: begin
                if (tick_i) begin
                    // Saturates naturally: all ones above range, zero below, no flag RULE15
                    if (!cmp_i) begin
                        st_nxt.trial[st_r.cnt] = 1'b0;
                    end
                    if (st_r.cnt == 4'h0) begin
                        st_nxt.state  = acc_pkg::SAR_IDLE;
                        st_nxt.result = cmp_i ? st_r.trial : {st_r.trial[9:1], 1'b0};
                        st_nxt.done   = 1'b1; // RULE16
                        st_nxt.trial  = 10'h000;
                    end else begin
                        st_nxt.trial[st_r.cnt - 4'h1] = 1'b1;
                        st_nxt.cnt = st_r.cnt - 4'h1;
                    end
                end
            end
            default: begin
                st_nxt.state = acc_pkg::SAR_IDLE;
            end
        endcase
        if (abort_i) begin
            st_nxt.state  = acc_pkg::SAR_IDLE;
            st_nxt.sample = 1'b0;
            st_nxt.trial  = 10'h000;
            st_nxt.done   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o   = (st_r.state != acc_pkg::SAR_IDLE);
    assign done_o   = st_r.done;
    assign sample_o = st_r.sample;
    assign trial_o  = st_r.trial;
    assign result_o = st_r.result;

    // ============================================================
    // Checks
    last_bit_done_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE16
        (st_r.state == acc_pkg::SAR_BITS && st_r.cnt == 4'h0 && tick_i && !abort_i) |=> done_o)
        else $error("conversion did not end after last bit");

endmodule // acc_sar

//--- logic/acc_top.sv
// Purpose: Control, status and result registers of a 10-bit successive approximation converter
// Assumes: Analog mux, sample switch and trial DAC outside; comparator result on ana_cmp_i
// Notes:   Every bus request gets waitrequest low on the second cycle
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "acc_regs.svh"
module acc_top #(
    parameter int          ADDR_W   = 9,
    parameter logic [15:0] STAB_CYC = 16'h0010
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              halt_i,
    input  wire logic              ana_cmp_i,
    output logic                   ana_power_o,
    output logic [3:0]             ana_channel_o,
    output logic                   ana_sample_o,
    output logic [9:0]             ana_trial_o
);
    localparam logic [ADDR_W-1:0] A_CSR = ADDR_W'({`ACC_IDX_CSR, 2'b00});
    localparam logic [ADDR_W-1:0] A_HI  = ADDR_W'({`ACC_IDX_RES_HI, 2'b00});
    localparam logic [ADDR_W-1:0] A_LO  = ADDR_W'({`ACC_IDX_RES_LO, 2'b00});

    localparam acc_pkg::acc_top_st_t ST_RST = '{
        ctrl:    acc_pkg::acc_ctrl_t'(6'h00),
        eoc:     1'b0,
        res:     `ACC_RES_RST,
        waitreq: 1'b1,
        rdata:   `ACC_CSR_RST,
        div:     2'h0,
        tick:    1'b0,
        stab:    16'h0000,
        power:   1'b0,
        chan:    4'h0
    };

    acc_pkg::acc_top_st_t st_r;
    acc_pkg::acc_top_st_t st_nxt;

    logic       sar_busy;
    logic       sar_done;
    logic       sar_sample;
    logic [9:0] sar_trial;
    logic [9:0] sar_result;

    logic       req;
    logic       acc;
    logic       wr_csr;
    logic       rd_hi;
    logic       ch_chg;
    logic       run;
    logic       sar_start;
    logic       sar_abort;
    logic [1:0] div_lim;
    logic [7:0] csr_view;

    // ============================================================
    // Bus decode
    // One idle cycle per request keeps read data registered at the cost of throughput
    always_comb begin
        req    = avs_read_i | avs_write_i;
        acc    = req & ~st_r.waitreq;
        wr_csr = acc & avs_write_i & avs_byteenable_i[0] & (avs_address_i == A_CSR);
        rd_hi  = acc & avs_read_i & (avs_address_i == A_HI);
        ch_chg = wr_csr & (avs_writedata_i[`ACC_CH_MSB:`ACC_CH_LSB] != st_r.ctrl.ch);
        // Reserved bit 4 reads zero
        csr_view = {st_r.eoc, st_r.ctrl.speed, st_r.ctrl.on, 1'b0, st_r.ctrl.ch};
    end

    // ============================================================
    // Converter enable
    // Wait mode has no input here on purpose: only halt gates the converter RULE8
    always_comb begin
        run       = st_r.ctrl.on & ~halt_i & (st_r.stab == 16'h0000); // RULE6 RULE9
        sar_abort = ~run | ch_chg; // RULE2 RULE6
        sar_start = run & ~sar_busy; // RULE13
        div_lim   = st_r.ctrl.speed ? `ACC_DIV_FAST : `ACC_DIV_SLOW; // RULE5
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;

        // Waitrequest drops for one cycle after a request is first seen
        if (req && st_r.waitreq) begin
            st_nxt.waitreq = 1'b0;
            case (avs_address_i)
                A_CSR:   st_nxt.rdata = csr_view;
                A_HI:    st_nxt.rdata = st_r.res[9:2]; // RULE10
                A_LO:    st_nxt.rdata = {6'h00, st_r.res[1:0]}; // RULE11
                default: st_nxt.rdata = 8'h00;
            endcase
        end else begin
            st_nxt.waitreq = 1'b1;
        end

        if (wr_csr) begin
            // Flag bit of the write data is dropped RULE4
            st_nxt.ctrl.speed = avs_writedata_i[`ACC_SPEED_BIT];
            st_nxt.ctrl.on    = avs_writedata_i[`ACC_ON_BIT];
            st_nxt.ctrl.ch    = avs_writedata_i[`ACC_CH_MSB:`ACC_CH_LSB]; // RULE7
            st_nxt.eoc        = 1'b0; // RULE3 RULE2
        end
        if (rd_hi) begin
            st_nxt.eoc = 1'b0; // RULE1
        end
        // Hardware set wins over a clear in the same cycle
        if (sar_done) begin
            st_nxt.eoc = 1'b1; // RULE3
            st_nxt.res = sar_result; // RULE16
        end

        // Converter tick divider, restarted on any control write
        if (wr_csr || st_r.div == div_lim) begin
            st_nxt.div = 2'h0;
        end else begin
            st_nxt.div = st_r.div + 2'h1;
        end
        st_nxt.tick = ~wr_csr & (st_r.div == div_lim); // RULE5

        // Stabilization wait after leaving halt
        if (halt_i) begin
            st_nxt.stab = STAB_CYC; // RULE9
        end else if (st_r.stab != 16'h0000) begin
            st_nxt.stab = st_r.stab - 16'h0001;
        end

        st_nxt.power = st_nxt.ctrl.on & ~halt_i; // RULE6 RULE9
        st_nxt.chan  = st_nxt.ctrl.ch; // RULE7
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= ST_RST; // RULE12
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Sequencer
    acc_sar u_sar (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .tick_i    (st_r.tick),
        .start_i   (sar_start),
        .abort_i   (sar_abort),
        .cmp_i     (ana_cmp_i),
        .busy_o    (sar_busy),
        .done_o    (sar_done),
        .sample_o  (sar_sample),
        .trial_o   (sar_trial),
        .result_o  (sar_result)
    );

    // ============================================================
    // Outputs
    assign avs_readdata_o    = {24'h000000, st_r.rdata};
    assign avs_waitrequest_o = st_r.waitreq;
    assign ana_power_o       = st_r.power;
    assign ana_channel_o     = st_r.chan;
    assign ana_sample_o      = sar_sample;
    assign ana_trial_o       = sar_trial;

    // ============================================================
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    hi_read_clear_a: assert property ((rd_hi && !sar_done) |=> !st_r.eoc) // RULE1
        else $error("high result read left the flag set");

    ch_change_restart_a: assert property ((ch_chg && !sar_done) |=> (!st_r.eoc && !sar_busy)) // RULE2
        else $error("channel change did not abort conversion");

    done_sets_flag_a: assert property (sar_done |=> (st_r.eoc && st_r.res == $past(sar_result))) // RULE3
        else $error("finished conversion did not set flag and result");

    flag_read_only_a: assert property ((wr_csr && avs_writedata_i[7] && !sar_done) |=> !st_r.eoc) // RULE4
        else $error("flag bit was writable");

    // A control write anywhere inside the tick period restarts the divider, so the spacing is only owed without one
    fast_rate_a: assert property ((st_r.tick && st_r.ctrl.speed && !wr_csr) ##1 !wr_csr // RULE5
        |-> (!st_r.tick ##1 st_r.tick))
        else $error("fast tick spacing is not two cycles");

    slow_rate_a: assert property ((st_r.tick && !st_r.ctrl.speed && !wr_csr) ##1 (!wr_csr)[*3] // RULE5
        |-> (!st_r.tick ##1 st_r.tick))
        else $error("slow tick spacing is not four cycles");

    off_stops_a: assert property (!st_r.ctrl.on |=> (!sar_busy && !ana_sample_o)) // RULE6
        else $error("conversion running while converter off");

    halt_disables_a: assert property (halt_i |=> (!ana_power_o && !sar_busy)) // RULE9
        else $error("converter active in halt");

    hi_read_map_a: assert property ((acc && avs_read_i && avs_address_i == A_HI) // RULE10
        |-> avs_readdata_o == {24'h000000, $past(st_r.res[9:2])})
        else $error("high result bits misplaced");

    lo_read_zero_a: assert property ((acc && avs_read_i && avs_address_i == A_LO) // RULE11
        |-> avs_readdata_o[31:2] == 30'h00000000)
        else $error("low result upper bits not zero");

    lo_read_map_a: assert property ((acc && avs_read_i && avs_address_i == A_LO) // RULE11
        |-> avs_readdata_o[1:0] == $past(st_r.res[1:0]))
        else $error("low result bits misplaced");

    // ============================================================
    // Bus handshake
    wait_low_a: assert property ((req && st_r.waitreq) |=> !avs_waitrequest_o)
        else $error("request not answered in the next cycle");

    wait_back_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");

    // ============================================================
    // Analog side outputs
    chan_follow_a: assert property (wr_csr |=> ana_channel_o == $past(avs_writedata_i[3:0])) // RULE7
        else $error("channel output does not follow the write");

    power_follow_a: assert property (ana_power_o == (st_r.ctrl.on && !$past(halt_i))) // RULE6 RULE9
        else $error("power output does not follow enable and halt");

    // Results right after wakeup are unreliable, so no sampling until the wait has run out
    stab_hold_a: assert property ((st_r.stab != 16'h0000) |=> !ana_sample_o) // RULE9
        else $error("sampling started during stabilization");

    done_after_bits_a: assert property (sar_done |-> $past(sar_busy)) // RULE16
        else $error("conversion end without a running conversion");

    reset_clear_a: assert property ($fell(rst_i) |-> (st_r.res == 10'h000 && csr_view == 8'h00)) // RULE12
        else $error("registers not cleared by reset");

    restart_a: assert property ((run && !sar_busy && !ch_chg) |=> sar_busy) // RULE13
        else $error("conversion not restarted");

    conv_done_c: cover property (sar_done);
    chan_switch_c: cover property (ch_chg && sar_busy);
    hi_read_c: cover property (rd_hi && st_r.eoc);
    halt_wake_c: cover property ($fell(halt_i) && st_r.ctrl.on);
    stab_wait_c: cover property (st_r.stab != 16'h0000 && st_r.ctrl.on);

endmodule // acc_top
